/* File: src/rtc_cmp_if.sv */
`timescale 1ns/1ps
// Threshold comparison signals between top and comparator
interface rtc_cmp_if;
    logic [31:0] velocity;   // Signed actual velocity
    logic [14:0] thresh;     // Stored threshold field
    logic        reached;    // Threshold enabled and reached
    modport top (output velocity, output thresh, input reached);
    modport cmp (input velocity, input thresh, output reached);
endinterface : rtc_cmp_if

/* File: src/rtc_pkg.sv */
package rtc_pkg;
    // Register offsets on the serial register interface
    localparam logic [6:0]  TARGET_OFS       = 7'h28;
    localparam logic [6:0]  THRESH_OFS       = 7'h29;
    // Threshold field position inside its register
    localparam int          THRESH_LSB       = 8;
    localparam int          THRESH_MSB       = 22;
    localparam int          THRESH_W         = 15;
    // Reset values
    localparam logic [31:0] TARGET_RST       = 32'h0000_0000;
    localparam logic [14:0] THRESH_RST       = 15'h0000;
    // Ramp mode that positions toward the target
    localparam logic [1:0]  RAMP_POSITIONING = 2'h0;

    // All state of the top module
    typedef struct packed {
        logic [31:0] target;      // Target position
        logic [14:0] thresh;      // Commutation velocity threshold
        logic        start;       // Positioning move start pulse
        logic        active;      // Automatic commutation engaged
        logic [31:0] pos_value;   // Position fed back to actual position
        logic [31:0] min_vel;     // Minimum step velocity while engaged
        logic [31:0] rdata;       // Read data
    } rtc_state_s;
endpackage : rtc_pkg

/* File: src/rtc_thresh_cmp.sv */
`timescale 1ns/1ps
// Compares velocity magnitude with the threshold field
module rtc_thresh_cmp (
    rtc_cmp_if.cmp cmp
);
    logic [31:0] magnitude;   // Absolute value of the velocity

    // Magnitude of a signed velocity
    always_comb
    begin
        if (cmp.velocity[31])
        begin
            magnitude = 32'h0000_0000 - cmp.velocity;
        end
        else
        begin
            magnitude = cmp.velocity;
        end
    end

    // Bits 7:0 take no part; any set bit in 31:23 always exceeds the field
    always_comb
    begin
        if (cmp.thresh == 15'h0000)
        begin
            cmp.reached = 1'b0;
        end
        else
        begin
            cmp.reached = (magnitude[31:23] != 9'h000)
                || (magnitude[22:8] >= cmp.thresh);
        end
    end
endmodule : rtc_thresh_cmp

/* File: src/rtc_top.sv */
`timescale 1ns/1ps
// Operation
// - target write in mode zero starts move
// - target is 32 bits, wraps freely
// - target rewrite starts new acceleration phase
// - zero threshold keeps commutation off
// - engage at magnitude >= threshold >= 256
// - engaging triggers high-velocity threshold actions
// - only bits 22:8 stored and compared
// - only with internal ramp generator driving
// - never in external step/direction mode
// - commutated position fed back to counter
// - threshold velocity is minimum step rate
module rtc_top (
    input  wire logic        clock,            // System clock
    input  wire logic        nrst,             // Async reset, active low
    input  wire logic        ce,               // Clock enable
    input  wire logic        wr_en,            // Register write strobe
    input  wire logic        rd_en,            // Register read strobe
    input  wire logic [6:0]  addr,             // Register address
    input  wire logic [31:0] wdata,            // Write data
    output logic      [31:0] rdata,            // Read data
    input  wire logic [1:0]  ramp_mode_select, // Ramp mode
    input  wire logic        internal_ramp,    // Ramp generator drives motor
    input  wire logic        step_dir_mode,    // External step/dir input mode
    input  wire logic [31:0] actual_velocity,  // Signed actual velocity
    input  wire logic [31:0] commutated_pos,   // Sensorless position
    output logic      [31:0] target_position,  // Target position
    output logic      [14:0] commutation_velocity_threshold, // Field
    output logic             move_start,       // Positioning start pulse
    output logic             commutation_active, // Auto commutation on
    output logic             high_velocity_threshold_act, // Same actions
    output logic             position_load,    // Load actual position
    output logic      [31:0] position_value,   // Value to load
    output logic      [31:0] min_step_velocity // Minimum step rate
);
    rtc_pkg::rtc_state_s state;      // Registered state
    rtc_pkg::rtc_state_s next_state; // Next state
    rtc_cmp_if           cmp_bus (); // Comparator link
    logic                wr_target;  // Write hits target register
    logic                wr_thresh;  // Write hits threshold register
    logic                allowed;    // Operating mode permits commutation

    // Threshold comparator
    rtc_thresh_cmp u_cmp (
        .cmp (cmp_bus.cmp)
    );

    assign cmp_bus.velocity = actual_velocity;
    assign cmp_bus.thresh   = state.thresh;
    assign wr_target = wr_en && (addr == rtc_pkg::TARGET_OFS);
    assign wr_thresh = wr_en && (addr == rtc_pkg::THRESH_OFS);
    assign allowed = internal_ramp && !step_dir_mode;

    // Next-state logic
    always_comb
    begin
        next_state       = state;
        next_state.start = 1'b0;
        if (wr_target)
        begin
            next_state.target = wdata;
            next_state.start  = (ramp_mode_select
                == rtc_pkg::RAMP_POSITIONING);
        end
        if (wr_thresh)
        begin
            next_state.thresh = wdata[rtc_pkg::THRESH_MSB:
                                      rtc_pkg::THRESH_LSB];
        end
        // Engage when allowed and threshold reached
        next_state.active    = allowed && cmp_bus.reached;
        next_state.pos_value = commutated_pos;
        next_state.min_vel   = {9'h000, state.thresh, 8'h00};
        // Register read path
        if (rd_en)
        begin
            case (addr)
                rtc_pkg::TARGET_OFS:
                begin
                    next_state.rdata = state.target;
                end
                rtc_pkg::THRESH_OFS:
                begin
                    next_state.rdata = {9'h000, state.thresh, 8'h00};
                end
                default:
                begin
                    next_state.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state.target    <= rtc_pkg::TARGET_RST;
            state.thresh    <= rtc_pkg::THRESH_RST;
            state.start     <= 1'b0;
            state.active    <= 1'b0;
            state.pos_value <= 32'h0000_0000;
            state.min_vel   <= 32'h0000_0000;
            state.rdata     <= 32'h0000_0000;
        end
        else if (ce)
        begin
            state <= next_state;
        end
    end

    // Outputs
    assign rdata                          = state.rdata;
    assign target_position                = state.target;
    assign commutation_velocity_threshold = state.thresh;
    assign move_start                     = state.start;
    assign commutation_active             = state.active;
    assign high_velocity_threshold_act    = state.active;
    assign position_load                  = state.active;
    assign position_value                 = state.pos_value;
    assign min_step_velocity              = state.min_vel;

    default clocking dc @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_target_write;
        ce && wr_target;
    endsequence
    sequence s_positioning;
        ramp_mode_select == rtc_pkg::RAMP_POSITIONING;
    endsequence

    a_move_start_pulse: assert property (
        s_target_write and s_positioning |=> move_start)
        else $error("target write did not start move");
    a_start_needs_write: assert property (
        move_start |-> $past(wr_target) && $past(ce))
        else $error("move start without target write");
    a_target_stored: assert property (
        s_target_write |=> target_position == $past(wdata))
        else $error("target value not stored");
    a_zero_thresh_off: assert property (
        ce && state.thresh == 15'h0000 |=> !commutation_active)
        else $error("commutation on with zero threshold");
    a_engage_check: assert property (
        ce && allowed && state.thresh != 15'h0000
        && actual_velocity[31] == 1'b0
        && actual_velocity[31:23] == 9'h000
        && actual_velocity[22:8] >= state.thresh |=> commutation_active)
        else $error("commutation did not engage");
    a_step_dir_off: assert property (
        ce && step_dir_mode |=> !commutation_active)
        else $error("commutation in step/dir mode");
    a_internal_only: assert property (
        ce && !internal_ramp |=> !commutation_active)
        else $error("commutation without internal ramp");
    a_thresh_field: assert property (
        ce && wr_thresh |=> commutation_velocity_threshold
        == $past(wdata[22:8]))
        else $error("threshold field wrong");
    a_reserved_zero: assert property (
        ce && rd_en && addr == rtc_pkg::THRESH_OFS |=> rdata[7:0] == 8'h00)
        else $error("reserved bits not zero");
    a_feedback_hold: assert property (
        commutation_active |-> position_load
        && high_velocity_threshold_act)
        else $error("feedback or threshold actions missing");
    // Commutation permitted and threshold armed
    sequence s_armed;
        ce && allowed && state.thresh != 15'h0000;
    endsequence
    // Reverse velocity whose magnitude clearly reaches the field
    sequence s_fast_reverse;
        actual_velocity[31] && actual_velocity[30:23] == 8'hFF
        && (~actual_velocity[22:8]) >= state.thresh;
    endsequence

    a_reverse_engage: assert property (
        s_armed and s_fast_reverse |=> commutation_active)
        else $error("commutation did not engage in reverse");
    a_no_start_other: assert property (
        ce && wr_target
        && ramp_mode_select != rtc_pkg::RAMP_POSITIONING
        |=> !move_start)
        else $error("move started outside positioning mode");
    a_start_one_cycle: assert property (
        ce && !wr_target |=> !move_start)
        else $error("move start without a new target write");
    a_target_holds: assert property (
        ce && !wr_target |=> $stable(target_position))
        else $error("target changed without a write");
    a_target_read: assert property (
        ce && rd_en && addr == rtc_pkg::TARGET_OFS
        |=> rdata == $past(target_position))
        else $error("target read back wrong");
    a_thresh_holds: assert property (
        ce && !wr_thresh |=> $stable(commutation_velocity_threshold))
        else $error("threshold changed without a write");
    a_feedback_value: assert property (
        ce |=> position_value == $past(commutated_pos))
        else $error("commutated position not fed back");
    a_min_step_rate: assert property (
        ce |=> min_step_velocity
        == {9'h000, $past(commutation_velocity_threshold), 8'h00})
        else $error("minimum step rate wrong");
endmodule : rtc_top

/* File: verif/rtc_top_tb.sv */
`timescale 1ns/1ps
module rtc_top_tb;
    logic        clock = 1'b0;   // System clock
    logic        nrst  = 1'b0;   // Reset, active low
    logic        ce    = 1'b1;   // Clock enable
    logic        wr_en = 1'b0;   // Write strobe
    logic        rd_en = 1'b0;   // Read strobe
    logic [6:0]  addr  = 7'h00;  // Register address
    logic [31:0] wdata = 32'h0;  // Write data
    logic [1:0]  mode  = 2'h0;   // Ramp mode
    logic        ir    = 1'b1;   // Internal ramp drives motor
    logic        sd    = 1'b0;   // Step/dir input mode
    logic [31:0] vel   = 32'h0;  // Actual velocity
    logic [31:0] cpos  = 32'h0;  // Commutated position
    logic [31:0] rdata, tgt, pval, minv; // Word outputs
    logic [14:0] th;             // Threshold field
    logic        ms, act, hva, pld; // Status outputs
    logic [31:0] rd_q[$];        // Expected read data
    logic        rd_pend = 1'b0; // Read taken last edge
    int          err_count = 0;  // Mismatches
    int          total_checks = 0; // Comparisons
    logic [31:0] d, m, last;     // Scratch words
    logic [14:0] tv;             // Scratch threshold
    logic        e;              // Expected engage
    // Boundary target values
    logic [31:0] edge_vals [3] = '{32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF};

    rtc_top uut (.clock(clock), .nrst(nrst), .ce(ce), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
        .ramp_mode_select(mode), .internal_ramp(ir), .step_dir_mode(sd),
        .actual_velocity(vel), .commutated_pos(cpos),
        .target_position(tgt), .commutation_velocity_threshold(th),
        .move_start(ms), .commutation_active(act),
        .high_velocity_threshold_act(hva), .position_load(pld),
        .position_value(pval), .min_step_velocity(minv));

    // Clock generator, 10 ns period
    always #5 clock = ~clock;

    // Counts and reports one comparison
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare

    // One register write, strobe held over the taking edge
    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        @(posedge clock);
        #1 wr_en = 1'b1; addr = a; wdata = v;
        @(posedge clock);
        #1 wr_en = 1'b0;
    endtask : wr

    // One register read, expected data queued for the monitor
    task automatic rd(input logic [6:0] a, input logic [31:0] v);
        @(posedge clock);
        #1 rd_en = 1'b1; addr = a; rd_q.push_back(v);
        @(posedge clock);
        #1 rd_en = 1'b0;
    endtask : rd

    // Monitor: read data is checked 2 ns after the taking edge
    always @(posedge clock)
    begin
        #2;
        if (rd_pend && rd_q.size() > 0)
            compare(rdata, rd_q.pop_front());
        rd_pend = rd_en && ce;
    end

    // Prints counts and verdict, then ends the run
    task automatic report_and_stop();
        $display("Checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // Watchdog against a hang
    initial
    begin
        #500000;
        err_count++;
        report_and_stop();
    end

    // Main sequence
    initial
    begin
        void'($urandom(32'h9343ea94));
        repeat (16) @(posedge clock);
        #1 nrst = 1'b1;
        compare({act, ms, th}, 32'h0);
        rd(rtc_pkg::TARGET_OFS, rtc_pkg::TARGET_RST);
        rd(rtc_pkg::THRESH_OFS, 32'h0);
        // Every ramp mode; only positioning starts a move
        for (int i = 0; i < 4; i++)
        begin
            // mode settled before the target write
            mode = 2'(i);
            last = $urandom;
            wr(rtc_pkg::TARGET_OFS, last);
            compare(tgt, last);
            compare(ms, i == 0);
        end
        mode = rtc_pkg::RAMP_POSITIONING;
        wr(rtc_pkg::TARGET_OFS, last);
        compare(ms, 1'b1);
        @(posedge clock);
        #1 compare(ms, 1'b0);
        // Boundary targets read back whole
        foreach (edge_vals[k])
        begin
            last = edge_vals[k];
            wr(rtc_pkg::TARGET_OFS, last);
            rd(rtc_pkg::TARGET_OFS, last);
        end
        // Unmapped place and frozen clock enable
        wr(7'h2A, $urandom);
        rd(7'h2A, 32'h0);
        ce = 1'b0;
        wr(rtc_pkg::TARGET_OFS, ~last);
        compare(ms, 1'b0);
        ce = 1'b1;
        rd(rtc_pkg::TARGET_OFS, last);
        wr(rtc_pkg::THRESH_OFS, 32'hFFFFFFFF);
        compare(th, 15'h7FFF);
        rd(rtc_pkg::THRESH_OFS, 32'h007FFF00);
        // Random velocities around random thresholds
        for (int i = 0; i < 60; i++)
        begin
            d = $urandom;
            if (i % 8 == 0)
                d[22:8] = 15'h0;
            wr(rtc_pkg::THRESH_OFS, d);
            tv = d[22:8];
            m = (({17'h0, tv} + $urandom_range(0, 2) - 1) << 8)
                | $urandom_range(0, 255);
            vel = (i % 5 == 0) ? $urandom : ($urandom_range(0, 1) ? -m : m);
            ir = $urandom_range(0, 3) != 0;
            sd = $urandom_range(0, 3) == 0;
            cpos = $urandom;
            m = vel[31] ? -vel : vel;
            e = ir && !sd && tv != 0 && (m[31:23] != 0 || m[22:8] >= tv);
            @(posedge clock);
            #1 compare(act, e);
            compare(hva, e);
            compare(pld, e);
            compare(pval, cpos);
            compare(minv, {9'h0, tv, 8'h0});
            compare(th, tv);
        end
        report_and_stop();
    end
endmodule : rtc_top_tb
